// ==== ddc_channel.sv ====
// One converter channel: staging and active code registers with trigger-timed update
module ddc_channel
  import ddc_pkg::*;
#(
  parameter int CODE_W = DDC_DATA_W
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wr,
  input wire logic [CODE_W-1:0] i_wdata,
  input wire logic i_realtime,
  input wire logic i_trig,
  input wire logic i_enable,
  output logic [CODE_W-1:0] o_active,
  output logic [CODE_W-1:0] o_read,
  output logic [CODE_W-1:0] o_code,
  output logic o_code_oe_n
);
  typedef struct packed {
    logic [CODE_W-1:0] staging;
    logic [CODE_W-1:0] active;
  } ddc_ch_s;

  ddc_ch_s st_reg;
  ddc_ch_s st_next;

  ////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_next = st_reg;
    if (i_wr)
    begin
      st_next.staging = i_wdata;
    end
    if (!i_realtime && i_wr)
    begin
      st_next.active = i_wdata;
    end
    else if (i_realtime && i_trig)
    begin
      // Staging does not yet hold a write made this cycle, so the write data is forwarded
      st_next.active = i_wr ? i_wdata : st_reg.staging;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st_reg.staging <= CODE_W'(DDC_CODE_RST);
      st_reg.active <= CODE_W'(DDC_CODE_RST);
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  assign o_active = st_reg.active;
  assign o_read = st_reg.active;
  // Ladder sees the active code; Vout = Vref * code / 256
  assign o_code = st_reg.active;
  assign o_code_oe_n = !i_enable;

  AST_RT_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_realtime && !i_trig) |=> $stable(st_reg.active))
    else $error("active code moved without trigger in real-time mode");
  AST_NORM_LOAD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!i_realtime && i_wr) |=> (st_reg.active == $past(i_wdata)))
    else $error("normal mode write not applied next cycle");
  AST_TRIG_LOAD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_realtime && i_trig && !i_wr) |=> (st_reg.active == $past(st_reg.staging)))
    else $error("trigger did not load staged code");
  AST_RT_READ: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_realtime && i_wr && !i_trig) |=> (o_read == $past(st_reg.active)))
    else $error("real-time read returned pending code");
  AST_STAGE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_wr |=> (st_reg.staging == $past(i_wdata)))
    else $error("write not captured in staging");
endmodule

// ==== ddc_ladder_model.sv ====
// Behavioural model of the two-channel resistor ladder output stage
module ddc_ladder_model
  import ddc_pkg::*;
#(
  parameter int VREF_UV = 3300000
)
(
  input wire logic [7:0] i_code0,
  input wire logic i_oe0_n,
  input wire logic [7:0] i_code1,
  input wire logic i_oe1_n,
  output int o_uv0,
  output int o_uv1,
  output logic [1:0] o_hiz
);
  timeunit 1ns;
  timeprecision 1ps;
  // A floating pin has no level, so a negative value marks it
  // Shared port pins are taken as inputs with pull-ups off, so only the ladder drives them
  assign o_hiz = {i_oe1_n, i_oe0_n};
  assign o_uv0 = i_oe0_n ? -1 : VREF_UV * int'(i_code0) / 256;
  assign o_uv1 = i_oe1_n ? -1 : VREF_UV * int'(i_code1) / 256;
endmodule

// ==== ddc_pkg.sv ====
// Package for the two-channel converter control: register map, field layout, reset values
package ddc_pkg;
  localparam int DDC_ADDR_W = 2;
  localparam int DDC_DATA_W = 8;
  localparam logic [1:0] DDC_OFS_CH0_CODE = 2'h0;
  localparam logic [1:0] DDC_OFS_CH1_CODE = 2'h1;
  localparam logic [1:0] DDC_OFS_MODE = 2'h2;
  localparam logic [7:0] DDC_CODE_RST = 8'h00;
  localparam logic [7:0] DDC_MODE_RST = 8'h00;
  localparam logic [7:0] DDC_RD_UNMAPPED = 8'h00;
  localparam int DDC_BIT_EN0 = 0;
  localparam int DDC_BIT_EN1 = 1;
  localparam int DDC_BIT_MSEL0 = 4;
  localparam int DDC_BIT_MSEL1 = 5;
  // Only bits 0, 1, 4 and 5 are implemented; the rest store nothing and read zero
  localparam logic [7:0] DDC_MODE_MASK = 8'h33;
  typedef enum logic {DDC_MODE_NORMAL, DDC_MODE_REALTIME} ddc_mode_e;
endpackage

// ==== ddc_top.sv ====
// Top of the two-channel converter control: register port, mode register, trigger sync
// Overview of operation
// - Chip reset clears both 8-bit channel code registers to zero and software writes them whole.
// - Each channel presents its code so the output is the reference times code over 256.
// - In real-time mode a code read before the next trigger returns the previously active value.
// - Chip reset clears the mode register, which takes both single-bit and whole-byte writes.
// - A disabled channel leaves its analog output in high impedance.
// - In real-time mode channel 0 triggers on timer 1 and channel 1 on timer 2.
// - Mode bit 4 selects channel 0 mode and bit 5 channel 1 mode, normal or real-time.
// - Mode bit 0 starts channel 0 conversion and bit 1 starts channel 1.
// - In normal mode an enabled channel drives the new code at once, with no trigger.
// - In real-time mode an enabled channel updates only with its own trigger.
// - Normal mode holds output until a new write; real-time mode holds a write pending for the trigger.
// - There are two independent 8-bit channels, each enabled and moded on its own.
//
// Added by the designer: the register offsets and the plain strobed port.
module ddc_top
  import ddc_pkg::*;
#(
  parameter int CODE_W = DDC_DATA_W
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [DDC_ADDR_W-1:0] i_addr,
  input wire logic [DDC_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DDC_DATA_W-1:0] o_rdata,
  input wire logic i_timer1_trigger,
  input wire logic i_timer2_trigger,
  output logic [CODE_W-1:0] o_analog_out_0,
  output logic o_analog_out_0_oe_n,
  output logic [CODE_W-1:0] o_analog_out_1,
  output logic o_analog_out_1_oe_n
);
  typedef struct packed {
    logic [DDC_DATA_W-1:0] mode;
    logic [DDC_DATA_W-1:0] rdata;
    logic [1:0] trig_meta;
    logic [1:0] trig_sync;
    logic [1:0] trig_prev;
  } ddc_top_s;

  ddc_top_s st_reg;
  ddc_top_s st_next;

  logic wr_ch0;
  logic wr_ch1;
  logic [1:0] trig_pulse;
  logic [CODE_W-1:0] rd_ch0;
  logic [CODE_W-1:0] rd_ch1;
  logic [CODE_W-1:0] act_ch0;
  logic [CODE_W-1:0] act_ch1;
  ddc_mode_e mode_ch0;
  ddc_mode_e mode_ch1;

  function automatic logic hit(input logic [DDC_ADDR_W-1:0] a, input logic [1:0] ofs);
    hit = (a == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////
  assign wr_ch0 = i_wr && hit(i_addr, DDC_OFS_CH0_CODE);
  assign wr_ch1 = i_wr && hit(i_addr, DDC_OFS_CH1_CODE);
  // Timer triggers come from elsewhere; rising edge after two flops
  assign trig_pulse = st_reg.trig_sync & ~st_reg.trig_prev;
  assign mode_ch0 = st_reg.mode[DDC_BIT_MSEL0] ? DDC_MODE_REALTIME : DDC_MODE_NORMAL;
  assign mode_ch1 = st_reg.mode[DDC_BIT_MSEL1] ? DDC_MODE_REALTIME : DDC_MODE_NORMAL;

  always_comb
  begin
    st_next = st_reg;
    st_next.trig_meta = {i_timer2_trigger, i_timer1_trigger};
    st_next.trig_sync = st_reg.trig_meta;
    st_next.trig_prev = st_reg.trig_sync;
    if (i_wr && hit(i_addr, DDC_OFS_MODE))
    begin
      // Bit writes arrive as read-modify-write bytes; unused bits never store
      st_next.mode = i_wdata & DDC_MODE_MASK;
    end
    st_next.rdata = DDC_RD_UNMAPPED;
    if (i_rd)
    begin
      if (hit(i_addr, DDC_OFS_CH0_CODE))
      begin
        st_next.rdata = DDC_DATA_W'(rd_ch0);
      end
      else if (hit(i_addr, DDC_OFS_CH1_CODE))
      begin
        st_next.rdata = DDC_DATA_W'(rd_ch1);
      end
      else if (hit(i_addr, DDC_OFS_MODE))
      begin
        st_next.rdata = st_reg.mode;
      end
      else
      begin
        st_next.rdata = DDC_RD_UNMAPPED;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st_reg.mode <= DDC_MODE_RST;
      st_reg.rdata <= DDC_RD_UNMAPPED;
      st_reg.trig_meta <= 2'h0;
      st_reg.trig_sync <= 2'h0;
      st_reg.trig_prev <= 2'h0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Two independent channels
  ddc_channel #(.CODE_W(CODE_W)) u_ch0 (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_wr(wr_ch0),
    .i_wdata(CODE_W'(i_wdata)),
    .i_realtime(mode_ch0 == DDC_MODE_REALTIME),
    .i_trig(trig_pulse[0]),
    .i_enable(st_reg.mode[DDC_BIT_EN0]),
    .o_active(act_ch0),
    .o_read(rd_ch0),
    .o_code(o_analog_out_0),
    .o_code_oe_n(o_analog_out_0_oe_n)
  );

  ddc_channel #(.CODE_W(CODE_W)) u_ch1 (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_wr(wr_ch1),
    .i_wdata(CODE_W'(i_wdata)),
    .i_realtime(mode_ch1 == DDC_MODE_REALTIME),
    .i_trig(trig_pulse[1]),
    .i_enable(st_reg.mode[DDC_BIT_EN1]),
    .o_active(act_ch1),
    .o_read(rd_ch1),
    .o_code(o_analog_out_1),
    .o_code_oe_n(o_analog_out_1_oe_n)
  );

  assign o_rdata = st_reg.rdata;

  ////////////////////////////////////////////////////////////////
  AST_EN0_OE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_analog_out_0_oe_n == !st_reg.mode[DDC_BIT_EN0])
    else $error("channel 0 drive does not follow its enable");
  AST_EN1_WRITE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_wr && hit(i_addr, DDC_OFS_MODE) && i_wdata[DDC_BIT_EN1]) |=> !o_analog_out_1_oe_n)
    else $error("channel 1 enable write did not start output");
  AST_MODE_RB: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_wr && hit(i_addr, DDC_OFS_MODE)) ##1 (i_rd && hit(i_addr, DDC_OFS_MODE))
      |=> (o_rdata == ($past(i_wdata, 2) & DDC_MODE_MASK)))
    else $error("mode register readback wrong");
  AST_TRIG_LAT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ($rose(i_timer1_trigger) ##1 $stable(i_timer1_trigger)) |=> trig_pulse[0])
    else $error("timer 1 trigger not seen in three cycles");
  AST_RT1_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_reg.mode[DDC_BIT_MSEL1] && !trig_pulse[1] && !wr_ch1) |=> $stable(o_analog_out_1))
    else $error("channel 1 changed without trigger");
  AST_NORM0: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!st_reg.mode[DDC_BIT_MSEL0] && wr_ch0) |=> (o_analog_out_0 == $past(i_wdata)))
    else $error("channel 0 normal write not applied");
  AST_RD0: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_rd && hit(i_addr, DDC_OFS_CH0_CODE)) |=> (o_rdata == $past(act_ch0)))
    else $error("channel 0 read not the active code");
  AST_UNMAP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_rd && i_addr == 2'h3) |=> (o_rdata == DDC_RD_UNMAPPED))
    else $error("unmapped read not zero");
  AST_TRIG2_LAT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ($rose(i_timer2_trigger) ##1 $stable(i_timer2_trigger)) |=> trig_pulse[1])
    else $error("timer 2 trigger not seen in three cycles");
  AST_EN1_OE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_analog_out_1_oe_n == !st_reg.mode[DDC_BIT_EN1])
    else $error("channel 1 drive does not follow its enable");
  AST_EN0_WRITE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_wr && hit(i_addr, DDC_OFS_MODE) && i_wdata[DDC_BIT_EN0]) |=> !o_analog_out_0_oe_n)
    else $error("channel 0 enable write did not start output");
  AST_RT0_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_reg.mode[DDC_BIT_MSEL0] && !trig_pulse[0] && !wr_ch0) |=> $stable(o_analog_out_0))
    else $error("channel 0 changed without trigger");
  AST_NORM1: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!st_reg.mode[DDC_BIT_MSEL1] && wr_ch1) |=> (o_analog_out_1 == $past(i_wdata)))
    else $error("channel 1 normal write not applied");
  AST_RD1: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_rd && hit(i_addr, DDC_OFS_CH1_CODE)) |=> (o_rdata == $past(act_ch1)))
    else $error("channel 1 read not the active code");
  AST_RD_IDLE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_rd |=> (o_rdata == DDC_RD_UNMAPPED))
    else $error("read data stood longer than one cycle");
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the two-channel converter control
module tb_top
  import ddc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int VREF_UV = 3300000;
  logic i_clk, i_rst_n, i_wr, i_rd;
  logic [1:0] i_addr, trg;
  logic [7:0] i_wdata, o_rdata, out0, out1;
  logic oe0_n, oe1_n;
  logic [1:0] hiz;
  int uv0, uv1, errors, total_checks, cycles;
  int act[2], stg[2], mode;
  ddc_top ddc_top_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_timer1_trigger(trg[0]),
    .i_timer2_trigger(trg[1]), .o_analog_out_0(out0), .o_analog_out_0_oe_n(oe0_n),
    .o_analog_out_1(out1), .o_analog_out_1_oe_n(oe1_n));
  ddc_ladder_model #(.VREF_UV(VREF_UV)) ddc_ladder_model_i (.i_code0(out0), .i_oe0_n(oe0_n),
    .i_code1(out1), .i_oe1_n(oe1_n), .o_uv0(uv0), .o_uv1(uv1), .o_hiz(hiz));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check_out();
    chk(oe0_n, !mode[0]);
    chk(oe1_n, !mode[1]);
    chk(hiz, {!mode[1], !mode[0]});
    if (mode[0]) chk(out0, act[0]);
    if (mode[1]) chk(out1, act[1]);
    if (mode[0]) chk(uv0, VREF_UV * act[0] / 256);
    if (mode[1]) chk(uv1, VREF_UV * act[1] / 256);
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    if (a < 2)
    begin
      stg[a] = d;
      if (!mode[4 + a]) act[a] = d;
    end
    else if (a == 2) mode = d & 8'h33;
    @(posedge i_clk);
    #1 check_out();
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, a < 2 ? act[a] : (a == 2 ? mode : 0));
    @(posedge i_clk);
    #1 chk(o_rdata, 8'h00);
  endtask
  // Pin held high two cycles so the synchroniser cannot miss it
  task automatic pulse(input int ch);
    @(posedge i_clk);
    trg[ch] <= 1'b1;
    @(posedge i_clk);
    @(posedge i_clk);
    trg[ch] <= 1'b0;
    #1 check_out();
    if (mode[4 + ch]) act[ch] = stg[ch];
    @(posedge i_clk);
    #1 check_out();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors++;
      close_out();
    end
  end
  initial
  begin
    logic [7:0] modes[3];
    modes = '{8'h13, 8'h23, 8'h33};
    {i_rst_n, i_wr, i_rd, i_addr, i_wdata, trg} = '0;
    {errors, total_checks, cycles, mode} = '0;
    act = '{0, 0};
    stg = '{0, 0};
    void'($urandom(32'hA2BA));
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (int a = 0; a < 4; a++) rd(a);
    #1 check_out();
    for (int a = 0; a < 2; a++) wr(a, 8'($urandom));
    wr(2, 8'h03);
    for (int a = 0; a < 2; a++) wr(a, 8'($urandom));
    for (int a = 0; a < 3; a++) rd(a);
    foreach (modes[m])
    begin
      wr(2, modes[m]);
      for (int a = 0; a < 2; a++) wr(a, 8'($urandom));
      for (int a = 0; a < 3; a++) rd(a);
      pulse(0);
      rd(0);
      pulse(1);
      rd(1);
    end
    wr(2, 8'h01);
    wr(2, 8'h00);
    rd(3);
    // Second reset after codes were loaded, so the clear is visible
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    mode = 0;
    act = '{0, 0};
    stg = '{0, 0};
    for (int a = 0; a < 3; a++) rd(a);
    wr(2, 8'h03);
    close_out();
  end
endmodule
